// [shared/ara_params.svh]
`ifndef ARA_PARAMS_SVH
`define ARA_PARAMS_SVH
// Word layout on the parallel port
`define ARA_ADDR_HI 15
`define ARA_ADDR_LO 14
`define ARA_REG_W 14
`define ARA_CTRL_ZERO_HI 13
`define ARA_CTRL_ZERO_LO 10
`define ARA_RDSEL_HI 7
`define ARA_RDSEL_LO 6
`define ARA_CONVERSION_START_BIT 4
`define ARA_STCAL_BIT 0
`define ARA_CTRL_RESET 14'h0000
`define ARA_TEST_RESET 14'h0000
`define ARA_CAL_RESET 14'h0000
`define ARA_CAL_COUNT 10
// Timing in core_clk cycles
`define ARA_CONV_CYCLES 16
`define ARA_CAL_CYCLES 64
`define ARA_STROBE_CYCLES 3
// Host APB register offsets
`define ARA_APB_CMD 8'h00
`define ARA_APB_WDATA 8'h04
`define ARA_APB_RDATA 8'h08
`define ARA_APB_STATUS 8'h0c
// Host command and status bits
`define ARA_CMD_WRITE 0
`define ARA_CMD_READ 1
`define ARA_CMD_UPPER_BYTE_ENABLE 2
`define ARA_CMD_CONV 3
`define ARA_CMD_PAIR 4
`define ARA_ST_SEQ 0
`define ARA_ST_BUSY 1
`define ARA_ST_DONE 2
`define ARA_ST_REFUSED 3
`endif

// [shared/ara_pkg.sv]
`default_nettype none
package ara_pkg;
  // Write address code, order matches the two top word bits
  typedef enum logic [1:0] {ARA_W_NONE, ARA_W_TEST, ARA_W_CAL, ARA_W_CTRL} ara_waddr_t;
  // Read select code, order matches the control field
  typedef enum logic [1:0] {ARA_R_DATA, ARA_R_TEST, ARA_R_CAL, ARA_R_STATUS} ara_rsel_t;
  typedef enum {ARA_H_IDLE, ARA_H_WLO, ARA_H_WGAP, ARA_H_WHI, ARA_H_RLO, ARA_H_RGAP, ARA_H_RHI,
                ARA_H_CONV} ara_hstate_t;
endpackage : ara_pkg
`default_nettype wire

// [shared/ara_link_if.sv]
`default_nettype none
interface ara_link_if;
  logic cs_n;
  logic rd_n;
  logic wr_n;
  logic upper_byte_enable;
  logic conversion_start_n;
  logic busy;
  logic [7:0] host_db_out;
  logic host_db_oe;
  logic [11:0] dev_db_out;
  logic dev_db_oe;
  logic [11:0] full_data_lines;
  // Bus level: device drive wins, undriven lines float high
  assign full_data_lines = dev_db_oe ? dev_db_out : (host_db_oe ? {4'hf, host_db_out} : 12'hfff);
  modport device (input cs_n, input rd_n, input wr_n, input upper_byte_enable, input conversion_start_n,
                  input full_data_lines, output busy, output dev_db_out, output dev_db_oe);
  modport host (output cs_n, output rd_n, output wr_n, output upper_byte_enable, output conversion_start_n,
                input full_data_lines, input busy, output host_db_out, output host_db_oe);
endinterface : ara_link_if
`default_nettype wire

// [core/ara_device.sv]
// Overview of operation
// [R1] Defaults allow read-only use without writes
// [R2] Control, data, status, test, ten calibration registers
// [R3] Host never writes the test register; ara_host sends such writes when ALLOW_TEST_WRITE is set
// [R4] Word sent low byte then high byte
// [R5] Each write byte on low eight lines
// [R6] Top two bits address, low fourteen stored
// [R7] Address 00 updates nothing
// [R8] Address 01 writes test register
// [R9] Address 10 writes selected calibration register
// [R10] Address 11 writes control register
// [R11] Control bits 7:6 choose read source
// [R12] Read select resets to output data
// [R13] Read select persists until rewritten
// [R14] Decode 00 data, 01 test, 10 cal, 11 status
// [R15] Output data reads four leading zeros
// [R16] Calibration reads fetch low byte first
// [R17] Upper byte enable picks byte; low gives 12 bits
// [R18] Control resets zero; bits 13:10 written zero
// [R19] Busy rises on start falling edge until done
// [R20] Byte toggle reset, cleared after each word
// [R21] Capture bytes only under chip select and write
//
// Register access over APB was left to the implementer.
`include "ara_params.svh"
`default_nettype none
module ara_device
  import ara_pkg::*;
#(
  parameter int CONV_CYCLES = `ARA_CONV_CYCLES,
  parameter int CAL_CYCLES = `ARA_CAL_CYCLES,
  parameter int CAL_COUNT = `ARA_CAL_COUNT
) (
  input wire logic core_clk,
  input wire logic resetn,
  ara_link_if.device link,
  input wire logic [11:0] sample_in,
  output logic [13:0] control_out,
  output logic [13:0] test_out
);
  localparam int PTR_W = $clog2(CAL_COUNT);
  localparam int CNT_W = $clog2(CAL_CYCLES + CONV_CYCLES + 1);

  logic wr_act;
  logic wr_act_d_reg;
  logic wr_take;
  logic rd_act;
  logic rd_act_d_reg;
  logic rd_upper_byte_enable_reg;
  logic rd_end;
  logic byte_toggle_reg;
  logic [7:0] low_byte_reg;
  logic [15:0] word;
  logic word_done;
  ara_waddr_t waddr;
  logic [13:0] control_reg;
  logic [13:0] test_reg;
  logic [13:0] cal_mem [CAL_COUNT];
  logic [PTR_W-1:0] cal_ptr_reg;
  logic [11:0] result_reg;
  logic busy_reg;
  logic busy_cal_reg;
  logic [CNT_W-1:0] busy_cnt_reg;
  logic start_n_d_reg;
  logic pin_start;
  logic ctrl_write;
  logic soft_start;
  logic cal_start;
  logic busy_end;
  ara_rsel_t rsel;
  logic [15:0] sel_word;
  logic [15:0] status_word;
  logic [11:0] dout_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Strobe qualification
  assign wr_act = !link.cs_n && !link.wr_n; // [R21]
  assign rd_act = !link.cs_n && !link.rd_n;
  assign wr_take = wr_act && !wr_act_d_reg;
  assign rd_end = rd_act_d_reg && !rd_act;

  // Edge history of the host strobes
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wr_act_d_reg <= 1'b0;
      rd_act_d_reg <= 1'b0;
      start_n_d_reg <= 1'b1;
    end else begin
      wr_act_d_reg <= wr_act;
      rd_act_d_reg <= rd_act;
      start_n_d_reg <= link.conversion_start_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte assembly: low byte first, then high byte completes the word
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      byte_toggle_reg <= 1'b0; // [R20]
      low_byte_reg <= 8'h00;
    end else if (wr_take) begin
      if (!byte_toggle_reg) begin
        low_byte_reg <= link.full_data_lines[7:0]; // [R4] [R5]
        byte_toggle_reg <= 1'b1;
      end else begin
        byte_toggle_reg <= 1'b0; // [R20]
      end
    end
  end

  // Upper byte enable is not needed on writes; the toggle orders the halves
  assign word = {link.full_data_lines[7:0], low_byte_reg}; // [R4] [R5]
  assign word_done = wr_take && byte_toggle_reg; // [R21]
  assign waddr = ara_waddr_t'(word[`ARA_ADDR_HI:`ARA_ADDR_LO]); // [R6] [R7]
  assign ctrl_write = word_done && (waddr == ARA_W_CTRL);
  // Address code none falls through every decode below
  assign soft_start = ctrl_write && word[`ARA_CONVERSION_START_BIT];
  assign cal_start = ctrl_write && word[`ARA_STCAL_BIT];
  assign pin_start = start_n_d_reg && !link.conversion_start_n;

  ////////////////////////////////////////////////////////////////////////////
  // Control register; a host write in the self-clear cycle wins
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      control_reg <= `ARA_CTRL_RESET; // [R1] [R12] [R18]
    end else begin
      if (busy_end && !busy_cal_reg) begin
        control_reg[`ARA_CONVERSION_START_BIT] <= 1'b0;
      end
      if (busy_end && busy_cal_reg) begin
        control_reg[`ARA_STCAL_BIT] <= 1'b0;
      end
      if (ctrl_write) begin
        control_reg <= word[`ARA_REG_W-1:0]; // [R10] [R13]
      end
    end
  end

  // Test register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      test_reg <= `ARA_TEST_RESET;
    end else if (word_done && (waddr == ARA_W_TEST)) begin
      test_reg <= word[`ARA_REG_W-1:0]; // [R8]
    end
  end

  // Calibration registers, one process per entry
  generate
    for (genvar i = 0; i < CAL_COUNT; i++) begin : g_cal
      always_ff @(posedge core_clk) begin
        if (!resetn) begin
          cal_mem[i] <= `ARA_CAL_RESET; // [R2]
        end else if (word_done && (waddr == ARA_W_CAL) && (cal_ptr_reg == PTR_W'(i))) begin
          cal_mem[i] <= word[`ARA_REG_W-1:0]; // [R9]
        end
      end
    end
  endgenerate

  // Calibration pointer: control write rewinds, each calibration write or high-byte calibration read steps on
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      cal_ptr_reg <= '0;
    end else if (ctrl_write) begin
      cal_ptr_reg <= '0;
    end else if ((word_done && (waddr == ARA_W_CAL)) || (rd_end && rd_upper_byte_enable_reg && (rsel == ARA_R_CAL))) begin
      // High byte ends a calibration read, so low must come first [R16]
      cal_ptr_reg <= (cal_ptr_reg == PTR_W'(CAL_COUNT - 1)) ? '0 : cal_ptr_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion and calibration timing, reported on busy
  assign busy_end = busy_reg && (busy_cnt_reg == '0);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      busy_reg <= 1'b0;
      busy_cal_reg <= 1'b0;
      busy_cnt_reg <= '0;
      result_reg <= 12'h000;
    end else if (busy_reg) begin
      if (busy_end) begin
        busy_reg <= 1'b0;
        if (!busy_cal_reg) begin
          result_reg <= sample_in;
        end
      end else begin
        busy_cnt_reg <= busy_cnt_reg - 1'b1;
      end
    end else if (cal_start) begin
      busy_reg <= 1'b1; // [R19]
      busy_cal_reg <= 1'b1;
      busy_cnt_reg <= CNT_W'(CAL_CYCLES - 1);
    end else if (pin_start || soft_start) begin
      busy_reg <= 1'b1; // [R19]
      busy_cal_reg <= 1'b0;
      busy_cnt_reg <= CNT_W'(CONV_CYCLES - 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path
  assign rsel = ara_rsel_t'(control_reg[`ARA_RDSEL_HI:`ARA_RDSEL_LO]); // [R11] [R13]
  assign status_word = {8'h00, busy_reg, busy_cal_reg, byte_toggle_reg, 1'b0, 4'(cal_ptr_reg)};

  always_comb begin
    case (rsel) // [R14]
      ARA_R_DATA: sel_word = {4'h0, result_reg}; // [R15]
      ARA_R_TEST: sel_word = {2'b00, test_reg};
      ARA_R_CAL: sel_word = {2'b00, cal_mem[cal_ptr_reg]};
      ARA_R_STATUS: sel_word = status_word;
      default: sel_word = 16'h0000;
    endcase
  end

  // Byte choice latched while the read strobe is active
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rd_upper_byte_enable_reg <= 1'b0;
    end else if (rd_act) begin
      rd_upper_byte_enable_reg <= link.upper_byte_enable;
    end
  end

  // Output lines refresh every cycle; one cycle behind a select change
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      dout_reg <= 12'h000;
    end else if (link.upper_byte_enable) begin
      dout_reg <= {4'h0, sel_word[15:8]}; // [R17]
    end else begin
      dout_reg <= sel_word[11:0]; // [R17]
    end
  end

  assign link.dev_db_out = dout_reg;
  assign link.dev_db_oe = rd_act;
  assign link.busy = busy_reg;
  assign control_out = control_reg;
  assign test_out = test_reg;
endmodule : ara_device
`default_nettype wire

// [core/ara_host.sv]
`include "ara_params.svh"
`default_nettype none
module ara_host
  import ara_pkg::*;
#(
  parameter int STROBE_CYCLES = `ARA_STROBE_CYCLES,
  parameter bit ALLOW_TEST_WRITE = 1'b0
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ara_link_if.host link
);
  ara_hstate_t state_reg;
  logic [7:0] cnt_reg;
  logic cnt_last;
  logic [15:0] wdata_reg;
  logic [15:0] rdata_reg;
  logic pair_reg;
  logic upper_byte_enable_reg;
  logic done_reg;
  logic refused_reg;
  logic [7:0] db_reg;
  logic acc;
  logic mapped;
  logic cmd_wr;
  logic done_set;
  logic [15:0] tx_word;
  logic [31:0] status_word;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, read data latched in setup
  assign mapped = (paddr == `ARA_APB_CMD) || (paddr == `ARA_APB_WDATA) || (paddr == `ARA_APB_RDATA) ||
                  (paddr == `ARA_APB_STATUS);
  assign acc = psel && penable;
  assign pready = acc;
  assign pslverr = acc && !mapped;
  assign cmd_wr = acc && pwrite && (paddr == `ARA_APB_CMD);
  assign status_word = {28'h0000000, refused_reg, done_reg, link.busy, state_reg != ARA_H_IDLE};

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `ARA_APB_WDATA: prdata <= {16'h0000, wdata_reg};
        `ARA_APB_RDATA: prdata <= {16'h0000, rdata_reg};
        `ARA_APB_STATUS: prdata <= status_word;
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // Write data word staged for the next write command
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wdata_reg <= 16'h0000;
    end else if (acc && pwrite && (paddr == `ARA_APB_WDATA)) begin
      wdata_reg <= pwdata[15:0];
    end
  end

  // Spare control bits forced to zero on control writes [R18]
  always_comb begin
    tx_word = wdata_reg;
    if (ara_waddr_t'(wdata_reg[`ARA_ADDR_HI:`ARA_ADDR_LO]) == ARA_W_CTRL) begin
      tx_word[`ARA_CTRL_ZERO_HI:`ARA_CTRL_ZERO_LO] = '0;
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  assign done_set = (cnt_last && ((state_reg == ARA_H_WHI) || (state_reg == ARA_H_CONV) ||
                    (state_reg == ARA_H_RHI) || ((state_reg == ARA_H_RLO) && !pair_reg)));
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      if (acc && pwrite && (paddr == `ARA_APB_STATUS) && pwdata[`ARA_ST_DONE]) begin
        done_reg <= 1'b0;
      end
      if (acc && pwrite && (paddr == `ARA_APB_STATUS) && pwdata[`ARA_ST_REFUSED]) begin
        refused_reg <= 1'b0;
      end
      if (done_set) begin
        done_reg <= 1'b1;
      end
      if (cmd_wr && pwdata[`ARA_CMD_WRITE] && (state_reg == ARA_H_IDLE) && !ALLOW_TEST_WRITE &&
          (ara_waddr_t'(wdata_reg[`ARA_ADDR_HI:`ARA_ADDR_LO]) == ARA_W_TEST)) begin
        refused_reg <= 1'b1; // [R3]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link sequencer
  assign cnt_last = (cnt_reg == 8'(STROBE_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_reg <= ARA_H_IDLE;
      cnt_reg <= 8'h00;
      db_reg <= 8'h00;
      pair_reg <= 1'b0;
      upper_byte_enable_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      cnt_reg <= (state_reg == ARA_H_IDLE || cnt_last) ? 8'h00 : cnt_reg + 8'h01;
      case (state_reg)
        ARA_H_IDLE: begin
          if (cmd_wr && pwdata[`ARA_CMD_WRITE]) begin
            if (ALLOW_TEST_WRITE || ara_waddr_t'(wdata_reg[`ARA_ADDR_HI:`ARA_ADDR_LO]) != ARA_W_TEST) begin
              state_reg <= ARA_H_WLO; // [R3]
              db_reg <= tx_word[7:0]; // [R4] [R5]
              upper_byte_enable_reg <= 1'b0; // [R17]
            end
          end else if (cmd_wr && pwdata[`ARA_CMD_PAIR]) begin
            state_reg <= ARA_H_RLO;
            pair_reg <= 1'b1;
            upper_byte_enable_reg <= 1'b0; // [R16]
          end else if (cmd_wr && pwdata[`ARA_CMD_READ]) begin
            state_reg <= ARA_H_RLO;
            pair_reg <= 1'b0;
            upper_byte_enable_reg <= pwdata[`ARA_CMD_UPPER_BYTE_ENABLE];
          end else if (cmd_wr && pwdata[`ARA_CMD_CONV]) begin
            state_reg <= ARA_H_CONV;
          end
        end
        ARA_H_WLO: if (cnt_last) begin
          state_reg <= ARA_H_WGAP;
          db_reg <= tx_word[15:8]; // [R4]
          upper_byte_enable_reg <= 1'b1; // [R17]
        end
        ARA_H_WGAP: if (cnt_last) state_reg <= ARA_H_WHI;
        ARA_H_WHI: if (cnt_last) state_reg <= ARA_H_IDLE;
        ARA_H_RLO: if (cnt_last) begin
          if (pair_reg) begin
            rdata_reg <= {8'h00, link.full_data_lines[7:0]};
            state_reg <= ARA_H_RGAP;
          end else begin
            rdata_reg <= {4'h0, link.full_data_lines}; // [R17]
            state_reg <= ARA_H_IDLE;
          end
        end
        ARA_H_RGAP: if (cnt_last) begin
          state_reg <= ARA_H_RHI;
          upper_byte_enable_reg <= 1'b1; // [R16]
        end
        ARA_H_RHI: if (cnt_last) begin
          rdata_reg <= {link.full_data_lines[7:0], rdata_reg[7:0]};
          state_reg <= ARA_H_IDLE;
          upper_byte_enable_reg <= 1'b0;
        end
        ARA_H_CONV: if (cnt_last) state_reg <= ARA_H_IDLE;
        default: state_reg <= ARA_H_IDLE;
      endcase
    end
  end

  // Strobes decoded from state; wr_n stays high in read-only use [R1]
  assign link.cs_n = !((state_reg == ARA_H_WLO) || (state_reg == ARA_H_WHI) || (state_reg == ARA_H_RLO) ||
                       (state_reg == ARA_H_RHI));
  assign link.wr_n = !((state_reg == ARA_H_WLO) || (state_reg == ARA_H_WHI)); // [R4]
  assign link.rd_n = !((state_reg == ARA_H_RLO) || (state_reg == ARA_H_RHI));
  assign link.upper_byte_enable = upper_byte_enable_reg; // [R17]
  assign link.conversion_start_n = (state_reg != ARA_H_CONV); // [R19]
  assign link.host_db_out = db_reg; // [R5]
  assign link.host_db_oe = (state_reg == ARA_H_WLO) || (state_reg == ARA_H_WGAP) || (state_reg == ARA_H_WHI);
endmodule : ara_host
`default_nettype wire

// [sim/ara_link_chk.sv]
`default_nettype none
module ara_link_chk #(
  parameter int CONV_CYCLES = 16,
  parameter int CAL_CYCLES = 64
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic upper_byte_enable,
  input wire logic conversion_start_n,
  input wire logic busy,
  input wire logic [7:0] host_db_out,
  input wire logic host_db_oe,
  input wire logic [11:0] dev_db_out,
  input wire logic dev_db_oe,
  input wire logic [11:0] full_data_lines
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dflt @(posedge core_clk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////////////
  // Length of the current busy run, judged when busy drops
  int run_cnt;
  always_ff @(posedge core_clk) begin
    if (!resetn || !busy) begin
      run_cnt <= 0;
    end else begin
      run_cnt <= run_cnt + 1;
    end
  end

  // Strobe shapes shared by several checks
  sequence rd_strobe;
    !cs_n && !rd_n;
  endsequence
  sequence wr_byte;
    (!cs_n && !wr_n)[*3];
  endsequence
  // Host still drives the high byte while the strobe is released
  sequence wr_gap;
    (wr_n && host_db_oe)[*3];
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  a_busy_on_start: assert property ($fell(conversion_start_n) && !busy |=> busy)
    else $error("busy did not rise after start edge");
  a_busy_run_len: assert property ($fell(busy) |-> (run_cnt == CONV_CYCLES || run_cnt == CAL_CYCLES))
    else $error("busy run length wrong");
  a_oe_tracks_read: assert property (dev_db_oe == (!cs_n && !rd_n))
    else $error("device drive not tied to read strobe");
  a_no_contention: assert property (!(dev_db_oe && host_db_oe))
    else $error("both ends drive the data lines");
  a_write_low_lines: assert property (!cs_n && !wr_n |-> host_db_oe && full_data_lines[7:0] == host_db_out)
    else $error("write byte not on low lines");
  a_write_strobe: assert property ($fell(wr_n) |-> wr_byte ##1 wr_n)
    else $error("write strobe shape wrong");
  a_no_rw_overlap: assert property (!(!wr_n && !rd_n))
    else $error("read and write strobes overlap");
  a_upper_byte_enable_steady: assert property (rd_strobe ##1 rd_strobe |-> $stable(upper_byte_enable))
    else $error("byte enable moved during read");
  a_upper_read_zero: assert property ((!cs_n && !rd_n && upper_byte_enable)[*2] |->
    full_data_lines[11:8] == 4'h0)
    else $error("upper byte read drives high lines");
  a_write_byte_order: assert property ($fell(wr_n) && !upper_byte_enable |->
    wr_byte ##1 wr_gap ##1 (!wr_n && upper_byte_enable))
    else $error("write bytes not sent low half then high half");
endmodule : ara_link_chk
`default_nettype wire

// [sim/tb_adc_register_access_decode.sv]
`include "ara_params.svh"
`default_nettype none
module tb_adc_register_access_decode;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, resetn, psel, penable, pwrite, pready, pslverr, last_err, saw_busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [11:0] sample_in;
  logic [13:0] control_out, test_out;
  int n_errors, n_checks;

  ////////////////////////////////////////////////////////////////////////////////
  ara_link_if u_ara_link_if();
  ara_device #(.CONV_CYCLES(4), .CAL_CYCLES(4)) u_ara_device (.core_clk(core_clk), .resetn(resetn),
    .link(u_ara_link_if.device), .sample_in(sample_in), .control_out(control_out), .test_out(test_out));
  // Test writes allowed so the test register decode is reachable
  ara_host #(.ALLOW_TEST_WRITE(1'b1)) u_ara_host (.core_clk(core_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(u_ara_link_if.host));
  ara_link_chk #(.CONV_CYCLES(4), .CAL_CYCLES(4)) u_ara_link_chk (.core_clk(core_clk), .resetn(resetn),
    .cs_n(u_ara_link_if.cs_n), .rd_n(u_ara_link_if.rd_n), .wr_n(u_ara_link_if.wr_n),
    .upper_byte_enable(u_ara_link_if.upper_byte_enable), .conversion_start_n(u_ara_link_if.conversion_start_n),
    .busy(u_ara_link_if.busy), .host_db_out(u_ara_link_if.host_db_out), .host_db_oe(u_ara_link_if.host_db_oe),
    .dev_db_out(u_ara_link_if.dev_db_out), .dev_db_oe(u_ara_link_if.dev_db_oe),
    .full_data_lines(u_ara_link_if.full_data_lines));

  // Clock and a sticky record of busy activity
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (u_ara_link_if.busy === 1'b1) saw_busy <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  // Poll until the sequencer and the busy pin are both quiet
  task automatic wait_idle;
    logic [31:0] s;
    s = 32'h3;
    while (s[1:0] !== 2'b00) apb(1'b0, `ARA_APB_STATUS, 32'h0, s);
  endtask : wait_idle

  // Bounded wait for busy activity, then for quiet
  task automatic wait_busy;
    int n;
    n = 0;
    while (saw_busy !== 1'b1 && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    wait_idle();
  endtask : wait_busy

  task automatic link_write(input logic [15:0] w);
    logic [31:0] r;
    apb(1'b1, `ARA_APB_WDATA, {16'h0000, w}, r);
    apb(1'b1, `ARA_APB_CMD, 32'h1, r);
    wait_idle();
  endtask : link_write

  task automatic link_read(input logic [31:0] cmd, output logic [31:0] r);
    apb(1'b1, `ARA_APB_CMD, cmd, r);
    wait_idle();
    apb(1'b0, `ARA_APB_RDATA, 32'h0, r);
  endtask : link_read

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({18'h0, control_out}, 32'h0);
    chk({18'h0, test_out}, 32'h0);
    link_read(32'h10, q);
    chk({16'h0, q[15:0]}, 32'h0);
    $display("test reset done");
  endtask : t_reset

  // Conversion then reads in every byte mode
  task automatic t_convert;
    sample_in <= 12'habc;
    saw_busy = 1'b0;
    apb(1'b1, `ARA_APB_CMD, 32'h8, q);
    wait_busy();
    chk({31'h0, saw_busy}, 32'h1);
    link_read(32'h2, q);
    chk({20'h0, q[11:0]}, 32'habc);
    link_read(32'h6, q);
    chk({24'h0, q[7:0]}, 32'h0a);
    link_read(32'h10, q);
    chk({16'h0, q[15:0]}, 32'h0abc);
    $display("test convert done");
  endtask : t_convert

  // Address decode of the none, test and control write codes and read select persistence
  task automatic t_decode;
    apb(1'b1, `ARA_APB_STATUS, 32'hc, q);
    apb(1'b0, `ARA_APB_STATUS, 32'h0, q);
    chk({28'h0, q[3:0]}, 32'h0);
    link_write(16'h5234);
    chk({18'h0, test_out}, 32'h1234);
    apb(1'b0, `ARA_APB_STATUS, 32'h0, q);
    chk({28'h0, q[3:0]}, 32'h4);
    chk({18'h0, control_out}, 32'h0);
    link_write(16'h3fff);
    chk({18'h0, test_out}, 32'h1234);
    chk({18'h0, control_out}, 32'h0);
    link_write(16'hfc40);
    chk({18'h0, control_out}, 32'h0040);
    repeat (2) begin
      link_read(32'h10, q);
      chk({16'h0, q[15:0]}, 32'h1234);
    end
    link_read(32'h2, q);
    chk({20'h0, q[11:0]}, 32'h234);
    $display("test decode done");
  endtask : t_decode

  // Calibration write and read back, status, calibration start
  task automatic t_cal;
    link_write(16'hc080);
    link_write(16'haa5c);
    link_write(16'hc080);
    link_read(32'h10, q);
    chk({16'h0, q[15:0]}, 32'h2a5c);
    link_write(16'hc0c0);
    link_read(32'h10, q);
    chk({16'h0, q[15:0]}, 32'h0000);
    saw_busy = 1'b0;
    link_write(16'hc001);
    wait_busy();
    chk({31'h0, saw_busy}, 32'h1);
    chk({18'h0, control_out}, 32'h0);
    $display("test calibration done");
  endtask : t_cal

  // Unmapped host address answers with an error and zero
  task automatic t_unmapped;
    apb(1'b0, 8'h10, 32'h0, q);
    chk(q, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    $display("test unmapped done");
  endtask : t_unmapped

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    give_verdict();
  end

  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sample_in = 12'h000;
    saw_busy = 1'b0;
    n_errors = 0;
    n_checks = 0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_convert();
    t_decode();
    t_cal();
    t_unmapped();
    give_verdict();
  end
endmodule : tb_adc_register_access_decode
`default_nettype wire
